// ---- instruction_word_operand_decoder_tb.sv ----
`include "iwod_defs.vh"
module instruction_word_operand_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic reset = 1'b1;
	int miscompares = 0;
	int n_tests = 0;
	wire [23:0] fetch_word;
	wire fetch_valid, dec_valid_q, dec_hold_q, two_word_q, byte_op_q, dest_to_file_q;
	wire bit_indirect_q, operand_is_file_q, accumulator_select_q, shift_from_register_q;
	wire [1:0] second_source_mode_q, destination_mode_q, x_prefetch_op_q, x_prefetch_dest_q;
	wire [1:0] y_prefetch_op_q, y_prefetch_dest_q, writeback_dest_q, table_mode_q;
	wire [2:0] category_q;
	wire [3:0] form_q, first_source_register_q, second_source_register_q, destination_register_q;
	wire [3:0] bit_position_q, mult_x_register_q, mult_y_register_q, shift_amount_register_q;
	wire [5:0] shift_literal_q;
	wire [7:0] opcode_q;
	wire [12:0] file_address_q;
	wire [15:0] literal_value_q;
	wire [22:0] program_address_q;
	iwod_pmem i_pm (.clock, .fetch_word, .fetch_valid);
	iwod_decoder i_dut (.clock, .reset, .fetch_word, .fetch_valid, .dec_valid_q, .dec_hold_q,
		.opcode_q, .category_q, .form_q, .two_word_q, .byte_op_q, .first_source_register_q,
		.second_source_register_q, .second_source_mode_q, .destination_register_q,
		.destination_mode_q, .file_address_q, .dest_to_file_q, .bit_position_q, .bit_indirect_q,
		.operand_is_file_q, .literal_value_q, .accumulator_select_q, .mult_x_register_q,
		.mult_y_register_q, .x_prefetch_op_q, .x_prefetch_dest_q, .y_prefetch_op_q,
		.y_prefetch_dest_q, .writeback_dest_q, .shift_from_register_q, .shift_amount_register_q,
		.shift_literal_q, .program_address_q, .table_mode_q);
	always #2 clock = ~clock;
	// ==========
	// Shared helpers.
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (miscompares == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic dec(input logic [7:0] op, input logic [15:0] f);
		i_pm.send({op, f});
		cmp(dec_valid_q, 1'b1);
		i_pm.idle();
		cmp(dec_valid_q, 1'b0);
	endtask
	function automatic logic [6:0] exp_cf(input logic [7:0] op);
		if (op <= 8'h3f) return {`IWOD_CAT_WORD, `IWOD_FORM_DEFAULT_WORKING_REGISTER};
		if (op <= 8'h5f) return {`IWOD_CAT_WORD, `IWOD_FORM_FILE};
		if (op <= 8'h7f) return {`IWOD_CAT_BIT, `IWOD_FORM_BIT};
		if (op <= 8'h8f) return {`IWOD_CAT_LIT, `IWOD_FORM_LMOV};
		if (op <= 8'haf) return {`IWOD_CAT_LIT, `IWOD_FORM_LALU};
		if (op <= 8'hbf) return {`IWOD_CAT_DSP, `IWOD_FORM_MAC};
		if (op <= 8'hcf) return {`IWOD_CAT_DSP, `IWOD_FORM_DSPO};
		if (op <= 8'hdf) return {`IWOD_CAT_CTL, `IWOD_FORM_CADDR};
		if (op <= 8'he7) return {`IWOD_CAT_CTL, `IWOD_FORM_CTBL};
		return {`IWOD_CAT_CTL, `IWOD_FORM_CNONE};
	endfunction
	// ==========
	// Scenarios.
	task automatic t_map();
		for (int i = 0; i < 256; i++) begin
			if (i < 208 || i > 210) begin
				dec(i[7:0], 16'h0000);
				cmp({category_q, form_q}, exp_cf(i[7:0]));
			end
		end
	endtask
	task automatic t_word();
		dec(8'h13, 16'ha9b7);
		cmp({first_source_register_q, second_source_register_q, byte_op_q}, 9'h14f);
		cmp({second_source_mode_q, destination_register_q, destination_mode_q}, 8'hda);
		dec(8'h45, 16'h1abc);
		cmp({dest_to_file_q, file_address_q}, 14'h1abc);
		dec(8'h47, 16'h6abc);
		cmp({byte_op_q, dest_to_file_q, operand_is_file_q, destination_register_q, file_address_q},
			20'he_0abc);
	endtask
	task automatic t_bit_lit();
		dec(8'h60, 16'h5a3c);
		cmp({bit_position_q, bit_indirect_q, operand_is_file_q, first_source_register_q}, 10'h168);
		dec(8'h61, 16'h2555);
		cmp({bit_indirect_q, operand_is_file_q, file_address_q}, 15'h0155 | 15'h2000);
		dec(8'h88, 16'hc35a);
		cmp({literal_value_q, file_address_q}, {16'h00c3, 13'h005a});
		dec(8'h80, 16'hc35a);
		cmp(literal_value_q, 16'h0c35);
		dec(8'h91, 16'h0abd);
		cmp({literal_value_q, destination_register_q, destination_mode_q}, {16'h002a, 6'h37});
		dec(8'h90, 16'h0abd);
		cmp(literal_value_q, 16'h00ab);
	endtask
	task automatic t_dsp();
		dec(8'hb1, 16'h9e5c);
		cmp({accumulator_select_q, mult_x_register_q, mult_y_register_q}, 9'h165);
		cmp({x_prefetch_op_q, x_prefetch_dest_q, y_prefetch_op_q, y_prefetch_dest_q,
			writeback_dest_q}, 10'h397);
		dec(8'hc2, 16'h7b40);
		cmp({accumulator_select_q, shift_from_register_q, shift_amount_register_q}, 6'h17);
		dec(8'hc1, 16'h7b40);
		cmp({accumulator_select_q, shift_from_register_q, shift_literal_q}, 8'had);
	endtask
	task automatic t_two();
		logic [15:0] lo;
		logic [6:0] hi;
		for (int i = 0; i < 3; i++) begin
			lo = 16'h1234 + i[15:0];
			hi = 7'h55 ^ i[6:0];
			i_pm.send({8'hd0 + i[7:0], lo});
			cmp({dec_valid_q, dec_hold_q}, 2'b01);
			if (i == 1) begin
				i_pm.idle();
				cmp({dec_valid_q, dec_hold_q}, 2'b01);
			end
			i_pm.send({8'hd0, 9'h000, hi});
			cmp({dec_valid_q, dec_hold_q, two_word_q, opcode_q}, {3'b101, 8'hd0 + i[7:0]});
			cmp(program_address_q, {hi, lo});
		end
		dec(8'hd5, 16'hbeef);
		cmp({two_word_q, program_address_q}, {1'b0, 7'h00, 16'hbeef});
		for (int i = 0; i < 4; i++) begin
			dec(8'he0 + i[7:0], 16'hffff);
			cmp(table_mode_q, i[1:0]);
		end
	endtask
	task automatic t_reset();
		i_pm.send({8'hd1, 16'h0001});
		cmp(dec_hold_q, 1'b1);
		reset = 1'b1;
		i_pm.idle();
		reset = 1'b0;
		cmp({category_q, form_q, dec_valid_q, dec_hold_q}, {3'h4, 4'h9, 2'b00});
		dec(8'h00, 16'h0000);
		cmp({two_word_q, opcode_q}, 9'h000);
	endtask
	initial begin
		repeat (16) @(posedge clock);
		#1;
		reset = 1'b0;
		cmp({category_q, form_q, dec_valid_q, dec_hold_q}, {3'h4, 4'h9, 2'b00});
		t_map();
		t_word();
		t_bit_lit();
		t_dsp();
		t_two();
		t_reset();
		conclude();
	end
	initial begin
		repeat (3000) @(posedge clock);
		miscompares++;
		conclude();
	end
endmodule // instruction_word_operand_decoder_tb

// ---- iwod_decoder.v ----
// How it works
// - Each word is 24 bits, an 8-bit opcode on top and operand fields below it.
// - Only three opcodes take a second program word; all others take one.
// - Every opcode falls into word/byte, bit, literal, DSP or control category.
// - Working-register word ops yield first source, second source with mode, destination with mode.
// - File-register word ops yield a file address and a destination select (file or register zero).
// - Bit ops yield a register or file operand and a bit position, literal or from first source.
// - Literal moves yield a literal and a register or file target to load it into.
// - Literal arithmetic yields first source, literal, and a destination: a separate one when flagged, else the first source.
// - Multiply-accumulate ops yield accumulator, two multiplicands, X/Y prefetch ops and targets, write-back.
// - Other DSP ops yield accumulator, operand with mode, and a shift from register or literal.
// - Control ops yield a program address or, for table access, a table mode.
`include "iwod_defs.vh"

module iwod_decoder (
	input wire clock,
	input wire reset,
	input wire [23:0] fetch_word,
	input wire fetch_valid,
	output reg dec_valid_q,
	output reg dec_hold_q,
	output reg [7:0] opcode_q,
	output reg [2:0] category_q,
	output reg [3:0] form_q,
	output reg two_word_q,
	output reg byte_op_q,
	output reg [3:0] first_source_register_q,
	output reg [3:0] second_source_register_q,
	output reg [1:0] second_source_mode_q,
	output reg [3:0] destination_register_q,
	output reg [1:0] destination_mode_q,
	output reg [12:0] file_address_q,
	output reg dest_to_file_q,
	output reg [3:0] bit_position_q,
	output reg bit_indirect_q,
	output reg operand_is_file_q,
	output reg [15:0] literal_value_q,
	output reg accumulator_select_q,
	output reg [3:0] mult_x_register_q,
	output reg [3:0] mult_y_register_q,
	output reg [1:0] x_prefetch_op_q,
	output reg [1:0] x_prefetch_dest_q,
	output reg [1:0] y_prefetch_op_q,
	output reg [1:0] y_prefetch_dest_q,
	output reg [1:0] writeback_dest_q,
	output reg shift_from_register_q,
	output reg [3:0] shift_amount_register_q,
	output reg [5:0] shift_literal_q,
	output reg [22:0] program_address_q,
	output reg [1:0] table_mode_q
);
	// =============================================================
	// Sequencing states
	localparam ST_FIRST = 1'b0;
	localparam ST_SECOND = 1'b1;

	reg state_q;
	reg state_d;
	reg [23:0] held_word_q;
	reg [23:0] held_word_d;
	reg [2:0] cat_hold_q;
	reg [3:0] form_hold_q;

	wire [7:0] opc;
	wire [15:0] opd;
	wire [2:0] cat_w;
	wire [3:0] form_w;
	wire two_w;
	wire [15:0] word2;
	reg emit;
	reg [7:0] op_e;
	reg [15:0] f;
	reg [2:0] cat_e;
	reg [3:0] form_e;

	assign opc = fetch_word[`IWOD_OPC_MSB:`IWOD_OPC_LSB];
	assign opd = fetch_word[`IWOD_OPD_W-1:0];
	assign word2 = fetch_word[`IWOD_OPD_W-1:0];

	iwod_opclass u_opclass (
		.opcode(opc),
		.category(cat_w),
		.form(form_w),
		.two_word(two_w)
	);

	// =============================================================
	// Two-word sequencing
	always @* begin
		state_d = state_q;
		held_word_d = held_word_q;
		emit = 1'b0;
		op_e = opc;
		f = opd;
		cat_e = cat_w;
		form_e = form_w;
		case (state_q)
			ST_FIRST: begin
				if (fetch_valid) begin
					if (two_w) begin
						state_d = ST_SECOND;
						held_word_d = fetch_word;
					end else begin
						emit = 1'b1;
					end
				end
			end
			ST_SECOND: begin
				op_e = held_word_q[`IWOD_OPC_MSB:`IWOD_OPC_LSB];
				f = held_word_q[`IWOD_OPD_W-1:0];
				cat_e = cat_hold_q;
				form_e = form_hold_q;
				if (fetch_valid) begin
					state_d = ST_FIRST;
					emit = 1'b1;
				end
			end
			default: begin
				state_d = ST_FIRST;
			end
		endcase
	end

	// =============================================================
	// Operand field extraction
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q <= ST_FIRST;
			held_word_q <= 24'h00_0000;
			cat_hold_q <= `IWOD_RST_CAT;
			form_hold_q <= `IWOD_RST_FORM;
			dec_valid_q <= 1'b0;
			dec_hold_q <= 1'b0;
			opcode_q <= 8'h00;
			category_q <= `IWOD_RST_CAT;
			form_q <= `IWOD_RST_FORM;
			two_word_q <= 1'b0;
			byte_op_q <= 1'b0;
			first_source_register_q <= 4'h0;
			second_source_register_q <= 4'h0;
			second_source_mode_q <= 2'h0;
			destination_register_q <= 4'h0;
			destination_mode_q <= 2'h0;
			file_address_q <= 13'h0000;
			dest_to_file_q <= 1'b0;
			bit_position_q <= 4'h0;
			bit_indirect_q <= 1'b0;
			operand_is_file_q <= 1'b0;
			literal_value_q <= 16'h0000;
			accumulator_select_q <= 1'b0;
			mult_x_register_q <= 4'h0;
			mult_y_register_q <= 4'h0;
			x_prefetch_op_q <= 2'h0;
			x_prefetch_dest_q <= 2'h0;
			y_prefetch_op_q <= 2'h0;
			y_prefetch_dest_q <= 2'h0;
			writeback_dest_q <= 2'h0;
			shift_from_register_q <= 1'b0;
			shift_amount_register_q <= 4'h0;
			shift_literal_q <= 6'h00;
			program_address_q <= 23'h00_0000;
			table_mode_q <= 2'h0;
		end else begin
			state_q <= state_d;
			held_word_q <= held_word_d;
			if (state_q == ST_FIRST && fetch_valid && two_w) begin
				cat_hold_q <= cat_w;
				form_hold_q <= form_w;
			end
			dec_valid_q <= emit;
			dec_hold_q <= (state_d == ST_SECOND);
			if (emit) begin
				opcode_q <= op_e;
				category_q <= cat_e;
				form_q <= form_e;
				two_word_q <= (state_q == ST_SECOND);
				byte_op_q <= op_e[0];
				first_source_register_q <= 4'h0;
				second_source_register_q <= f[`IWOD_WS_LSB +: 4];
				second_source_mode_q <= f[`IWOD_WSM_LSB +: 2];
				destination_register_q <= 4'h0;
				destination_mode_q <= 2'h0;
				file_address_q <= 13'h0000;
				dest_to_file_q <= 1'b0;
				bit_position_q <= 4'h0;
				bit_indirect_q <= 1'b0;
				operand_is_file_q <= 1'b0;
				literal_value_q <= 16'h0000;
				accumulator_select_q <= op_e[0];
				mult_x_register_q <= 4'h0;
				mult_y_register_q <= 4'h0;
				x_prefetch_op_q <= 2'h0;
				x_prefetch_dest_q <= 2'h0;
				y_prefetch_op_q <= 2'h0;
				y_prefetch_dest_q <= 2'h0;
				writeback_dest_q <= 2'h0;
				shift_from_register_q <= 1'b0;
				shift_amount_register_q <= 4'h0;
				shift_literal_q <= 6'h00;
				program_address_q <= 23'h00_0000;
				table_mode_q <= 2'h0;
				case (form_e)
					`IWOD_FORM_DEFAULT_WORKING_REGISTER: begin
						first_source_register_q <= f[`IWOD_WB_LSB +: 4];
						destination_register_q <= f[`IWOD_WD_LSB +: 4];
						destination_mode_q <= f[`IWOD_WDM_LSB +: 2];
					end
					`IWOD_FORM_FILE: begin
						file_address_q <= f[12:0];
						dest_to_file_q <= f[`IWOD_FILE_DEST_BIT];
						operand_is_file_q <= 1'b1;
						destination_register_q <= `IWOD_WORKING_REGISTER_ZERO;
						byte_op_q <= f[14];
					end
					`IWOD_FORM_BIT: begin
						bit_position_q <= f[`IWOD_WB_LSB +: 4];
						bit_indirect_q <= f[`IWOD_BIT_IND_BIT];
						operand_is_file_q <= f[`IWOD_BIT_FILE_BIT];
						file_address_q <= {3'h0, f[9:0]};
						first_source_register_q <= f[`IWOD_WD_LSB +: 4];
					end
					`IWOD_FORM_LMOV: begin
						operand_is_file_q <= op_e[3];
						if (op_e[3]) begin
							literal_value_q <= {8'h00, f[15:8]};
							file_address_q <= {5'h00, f[7:0]};
						end else begin
							literal_value_q <= {4'h0, f[15:4]};
							destination_register_q <= f[3:0];
						end
					end
					`IWOD_FORM_LALU: begin
						first_source_register_q <= f[`IWOD_WB_LSB +: 4];
						if (op_e[0]) begin
							literal_value_q <= {10'h000, f[11:6]};
							destination_register_q <= f[3:0];
							destination_mode_q <= f[5:4];
						end else begin
							literal_value_q <= {8'h00, f[11:4]};
							destination_register_q <= f[`IWOD_WB_LSB +: 4];
						end
					end
					`IWOD_FORM_MAC: begin
						mult_x_register_q <= {`IWOD_MULT_X_BASE, f[15:14]};
						mult_y_register_q <= {`IWOD_MULT_Y_BASE, f[13:12]};
						x_prefetch_op_q <= f[11:10];
						x_prefetch_dest_q <= f[9:8];
						y_prefetch_op_q <= f[7:6];
						y_prefetch_dest_q <= f[5:4];
						writeback_dest_q <= f[3:2];
					end
					`IWOD_FORM_DSPO: begin
						shift_from_register_q <= op_e[1];
						shift_literal_q <= f[11:6];
						shift_amount_register_q <= f[15:12];
						destination_register_q <= f[3:0];
						destination_mode_q <= f[5:4];
					end
					`IWOD_FORM_CADDR: begin
						if (state_q == ST_SECOND) begin
							program_address_q <= {word2[`IWOD_EXT_ADDR_W-1:0], f};
						end else begin
							program_address_q <= {7'h00, f};
						end
					end
					`IWOD_FORM_CTBL: begin
						table_mode_q <= op_e[1:0];
						destination_register_q <= f[`IWOD_WD_LSB +: 4];
						destination_mode_q <= f[`IWOD_WDM_LSB +: 2];
					end
					default: begin
						program_address_q <= 23'h00_0000;
					end
				endcase
			end
		end
	end
endmodule // iwod_decoder

// ---- iwod_decoder_properties.sv ----
`include "iwod_defs.vh"
module iwod_checker (
	input logic clock,
	input logic reset,
	input logic [23:0] fetch_word,
	input logic fetch_valid,
	input logic dec_valid_q,
	input logic dec_hold_q,
	input logic [7:0] opcode_q,
	input logic [2:0] category_q,
	input logic two_word_q,
	input logic [22:0] program_address_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic two_in;
	logic [15:0] low_q;
	assign two_in = fetch_word[23:16] inside {8'hd0, 8'hd1, 8'hd2};
	// ==========
	// Low address half of a pending two-word instruction.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			low_q <= 16'h0000;
		end else if (fetch_valid && !dec_hold_q) begin
			low_q <= fetch_word[15:0];
		end
	end
	function automatic logic [2:0] cat_of(input logic [7:0] op);
		if (op <= 8'h5f) return `IWOD_CAT_WORD;
		if (op <= 8'h7f) return `IWOD_CAT_BIT;
		if (op <= 8'haf) return `IWOD_CAT_LIT;
		if (op <= 8'hcf) return `IWOD_CAT_DSP;
		return `IWOD_CAT_CTL;
	endfunction
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	single_word_a: assert property (
		fetch_valid && !dec_hold_q && !two_in |=> dec_valid_q) else $error("word not decoded");
	hold_start_a: assert property (
		fetch_valid && !dec_hold_q && two_in |=> dec_hold_q && !dec_valid_q)
		else $error("two-word opcode did not hold");
	second_word_a: assert property (
		dec_hold_q && fetch_valid |=> dec_valid_q && !dec_hold_q && two_word_q)
		else $error("second word mishandled");
	valid_cause_a: assert property (
		dec_valid_q |-> $past(fetch_valid)) else $error("decode without a fetch");
	opcode_capture_a: assert property (
		fetch_valid && !dec_hold_q && !two_in |=> opcode_q == $past(fetch_word[23:16]))
		else $error("opcode not captured");
	category_map_a: assert property (
		dec_valid_q |-> category_q == cat_of(opcode_q)) else $error("wrong category");
	address_pair_a: assert property (
		dec_hold_q && fetch_valid |=> program_address_q == {$past(fetch_word[6:0]), low_q})
		else $error("wrong program address");
	fields_hold_a: assert property (
		!dec_valid_q && !dec_hold_q |-> $stable(opcode_q) && $stable(category_q))
		else $error("fields changed without decode");
endmodule // iwod_checker

bind iwod_decoder iwod_checker i_chk (.clock, .reset, .fetch_word, .fetch_valid, .dec_valid_q,
	.dec_hold_q, .opcode_q, .category_q, .two_word_q, .program_address_q);

// ---- iwod_defs.vh ----
`ifndef IWOD_DEFS_VH
`define IWOD_DEFS_VH

// =============================================================
// Word layout
`define IWOD_WORD_W 24
`define IWOD_OPC_MSB 23
`define IWOD_OPC_LSB 16
`define IWOD_OPD_W 16

// =============================================================
// Instruction categories
`define IWOD_CAT_WORD 3'h0
`define IWOD_CAT_BIT 3'h1
`define IWOD_CAT_LIT 3'h2
`define IWOD_CAT_DSP 3'h3
`define IWOD_CAT_CTL 3'h4

// =============================================================
// Operand forms
`define IWOD_FORM_DEFAULT_WORKING_REGISTER 4'h0
`define IWOD_FORM_FILE 4'h1
`define IWOD_FORM_BIT 4'h2
`define IWOD_FORM_LMOV 4'h3
`define IWOD_FORM_LALU 4'h4
`define IWOD_FORM_MAC 4'h5
`define IWOD_FORM_DSPO 4'h6
`define IWOD_FORM_CADDR 4'h7
`define IWOD_FORM_CTBL 4'h8
`define IWOD_FORM_CNONE 4'h9

// =============================================================
// Opcode region bounds (upper limit of each region)
`define IWOD_OP_DEFAULT_WORKING_REGISTER_END 8'h3f
`define IWOD_OP_FILE_END 8'h5f
`define IWOD_OP_BIT_END 8'h7f
`define IWOD_OP_LMOV_END 8'h8f
`define IWOD_OP_LALU_END 8'haf
`define IWOD_OP_MAC_END 8'hbf
`define IWOD_OP_DSPO_END 8'hcf
`define IWOD_OP_CADDR_END 8'hdf
`define IWOD_OP_CTBL_END 8'he7

// The three opcodes that take a second program word.
`define IWOD_OP_TWO_A 8'hd0
`define IWOD_OP_TWO_B 8'hd1
`define IWOD_OP_TWO_C 8'hd2

// =============================================================
// Operand field positions
`define IWOD_WS_LSB 0
`define IWOD_WSM_LSB 4
`define IWOD_WD_LSB 6
`define IWOD_WDM_LSB 10
`define IWOD_WB_LSB 12
`define IWOD_FILE_DEST_BIT 13
`define IWOD_BIT_IND_BIT 11
`define IWOD_BIT_FILE_BIT 10
`define IWOD_EXT_ADDR_W 7

// =============================================================
// Fixed register numbers
`define IWOD_WORKING_REGISTER_ZERO 4'h0
`define IWOD_MULT_X_BASE 2'h1
`define IWOD_MULT_Y_BASE 2'h1

// =============================================================
// Reset values
`define IWOD_RST_FORM 4'h9
`define IWOD_RST_CAT 3'h4

`endif

// ---- iwod_opclass.v ----
`include "iwod_defs.vh"

module iwod_opclass (
	input wire [7:0] opcode,
	output reg [2:0] category,
	output reg [3:0] form,
	output wire two_word
);
	// =============================================================
	// Opcode to category and form
	always @* begin
		category = `IWOD_CAT_CTL;
		form = `IWOD_FORM_CNONE;
		if (opcode <= `IWOD_OP_DEFAULT_WORKING_REGISTER_END) begin
			category = `IWOD_CAT_WORD;
			form = `IWOD_FORM_DEFAULT_WORKING_REGISTER;
		end else if (opcode <= `IWOD_OP_FILE_END) begin
			category = `IWOD_CAT_WORD;
			form = `IWOD_FORM_FILE;
		end else if (opcode <= `IWOD_OP_BIT_END) begin
			category = `IWOD_CAT_BIT;
			form = `IWOD_FORM_BIT;
		end else if (opcode <= `IWOD_OP_LMOV_END) begin
			category = `IWOD_CAT_LIT;
			form = `IWOD_FORM_LMOV;
		end else if (opcode <= `IWOD_OP_LALU_END) begin
			category = `IWOD_CAT_LIT;
			form = `IWOD_FORM_LALU;
		end else if (opcode <= `IWOD_OP_MAC_END) begin
			category = `IWOD_CAT_DSP;
			form = `IWOD_FORM_MAC;
		end else if (opcode <= `IWOD_OP_DSPO_END) begin
			category = `IWOD_CAT_DSP;
			form = `IWOD_FORM_DSPO;
		end else if (opcode <= `IWOD_OP_CADDR_END) begin
			form = `IWOD_FORM_CADDR;
		end else if (opcode <= `IWOD_OP_CTBL_END) begin
			form = `IWOD_FORM_CTBL;
		end
	end

	assign two_word = (opcode == `IWOD_OP_TWO_A) || (opcode == `IWOD_OP_TWO_B) ||
		(opcode == `IWOD_OP_TWO_C);
endmodule // iwod_opclass

// ---- iwod_pmem.sv ----
module iwod_pmem (
	input logic clock,
	output logic [23:0] fetch_word,
	output logic fetch_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fetch_word = 24'h00_0000;
		fetch_valid = 1'b0;
	end
	// Offers one word for one edge; the caller stands just after an edge.
	task automatic send(input logic [23:0] w);
		fetch_word = w;
		fetch_valid = 1'b1;
		@(posedge clock);
		#1;
	endtask
	// A released bus shows the inverse of the last word, never a stale copy.
	task automatic idle();
		fetch_word = ~fetch_word;
		fetch_valid = 1'b0;
		@(posedge clock);
		#1;
	endtask
endmodule // iwod_pmem
